// ---- verilog/boot_map_pkg.sv ----
// Constants and types for the program memory map selection block.
//
// Functional notes
// - The program memory map follows the two mode bits held in the operating_mode_register.
// - At reset the security_mode_bit loads from the flash secured state and the map_mode_bit from the boot strap.
// - With both mode bits 0 the device boots internally on 16 lines, secured, no external space, debug disabled.
// - A boot strap asking for external boot while the security bit is 0 is refused and both bits end up 00.
// - Both straps are pinned at 0 and cannot change, so only internal boot is possible; the code pins them only with PIN_STRAPS set, else the pins pass through.
// - Data flash reads go over the program-read bus or the secondary bus, never both in one cycle.
// - Flash erase or programming happens only via the flash interface unit with word writes on the write bus.
// - After reset, while the security_mode_bit is 1, a software write to the map_mode_bit changes the map; writing the security bit does not.
// - The security_mode_bit is captured only at reset and writing it does not touch flash security.
// - With both mode bits 1 the device boots externally, unsecured, with bus width from the memory mode strap.
`default_nettype none
package boot_map_pkg;
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int MODE_MA_BIT = 0;
  localparam int MODE_MB_BIT = 1;
  localparam int ST_BOOT_EXT_BIT = 0;
  localparam int ST_ADDR20_BIT = 1;
  localparam int ST_SECURED_BIT = 2;
  localparam int ST_PSPACE_BIT = 3;
  localparam int ST_DBG_DIS_BIT = 4;
  localparam int ST_STRAP_REF_BIT = 5;
  localparam int ST_WR_REF_BIT = 6;
  localparam int ST_RD_CONF_BIT = 7;
  localparam int ST_READY_BIT = 8;
  localparam int SYNC_CYCLES = 2;
  localparam int NARROW_ADDR_LINES = 16;
  localparam int WIDE_ADDR_LINES = 20;

  // Capture waits in SYNCING until the strap synchronisers hold settled values.
  typedef enum logic [0:0] {SYNCING, RUNNING} boot_state_t;

  typedef struct packed {
    logic boot_external;
    logic ext_addr_20;
    logic flash_secured;
    logic ext_pspace_allowed;
    logic debug_disabled;
  } map_cfg_t;

  // The safest map: internal boot, narrow bus, secured and no debug.
  localparam map_cfg_t CFG_RST = '{boot_external: 1'b0, ext_addr_20: 1'b0, flash_secured: 1'b1,
                                   ext_pspace_allowed: 1'b0, debug_disabled: 1'b1};
endpackage : boot_map_pkg
`default_nettype wire

// ---- verilog/boot_mode_program_map_select.sv ----
// Reset-time mode capture, program map decode and flash path guard with an AHB-Lite register port.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`default_nettype none
module boot_mode_program_map_select #(
  parameter bit PIN_STRAPS = 1'b1 // Straps tied low inside the package.
) (
  input wire logic hclk, // Core clock, 100 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Always ready.
  output logic hresp, // Always OKAY.
  output logic [31:0] hrdata, // Read data.
  input wire logic external_boot_strap, // Boot strap pin.
  input wire logic external_memory_mode_strap, // Bus width strap pin.
  input wire logic flash_secured, // Flash security state, high when secured.
  output boot_map_pkg::map_cfg_t map_cfg, // Decoded map configuration.
  input wire logic pread_req, // Data flash read on the program-read bus.
  input wire logic sread_req, // Data flash read on the secondary bus.
  output logic pread_gnt, // Program-read bus granted.
  output logic sread_gnt, // Secondary bus granted.
  input wire logic fiu_wr_req, // Flash write via the interface unit.
  input wire logic fiu_wr_word, // That write is a whole word.
  input wire logic other_wr_req, // Flash write attempt from any other path.
  output logic flash_wr_en, // Erase or program enable to the array.
  output logic flash_wr_refused // A write attempt was blocked this cycle.
);
  localparam int SYNC_CHECK = boot_map_pkg::SYNC_CYCLES;
  // The capture count assumes exactly two synchroniser stages and a two-bit counter.
  if (SYNC_CHECK != 2) begin : g_bad_sync
    $error("strap synchroniser must be two stages");
  end

  // Two-flop synchronisers for the strap pins.
  logic [1:0] boot_sync_q, boot_sync_d;
  logic [1:0] emi_sync_q, emi_sync_d;
  always_comb begin
    boot_sync_d = {boot_sync_q[0], external_boot_strap};
    emi_sync_d = {emi_sync_q[0], external_memory_mode_strap};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_sync_q <= 2'h0;
      emi_sync_q <= 2'h0;
    end else begin
      boot_sync_q <= boot_sync_d;
      emi_sync_q <= emi_sync_d;
    end
  end

  // Pinned straps read as zero whatever the pin does.
  logic boot_strap_s;
  logic emi_strap_s;
  assign boot_strap_s = PIN_STRAPS ? 1'b0 : boot_sync_q[1];
  assign emi_strap_s = PIN_STRAPS ? 1'b0 : emi_sync_q[1];

  // Bus address phase capture.
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic rd_en;
  logic wr_take;
  logic wr_mode;
  logic wr_status;
  assign rd_en = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  assign wr_mode = wr_pend_q && (wr_addr_q == boot_map_pkg::MODE_OFS);
  assign wr_status = wr_pend_q && (wr_addr_q == boot_map_pkg::STATUS_OFS);

  // Mode bits, captured values and sticky status.
  boot_map_pkg::boot_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic ma_q, ma_d;
  logic mb_q, mb_d;
  logic emi_q, emi_d;
  logic strap_ref_q, strap_ref_d;
  logic wr_ref_q, wr_ref_d;
  logic rd_conf_q, rd_conf_d;
  boot_map_pkg::map_cfg_t cfg_q, cfg_d;
  logic capture;
  logic rd_conflict;
  logic [31:0] status_word;
  logic [31:0] mode_word;

  // The synchronisers are cleared by reset, so the pin reaches the second stage only after two edges.
  // Capturing one edge earlier would always see a zero strap.
  assign capture = (state_q == boot_map_pkg::SYNCING) && (cnt_q == 2'(SYNC_CHECK));
  assign rd_conflict = pread_req && sread_req;

  // One cycle of both buses asking stalls the secondary bus; the core path must not wait.
  assign pread_gnt = pread_req;
  assign sread_gnt = sread_req && !pread_req;

  // Only whole-word writes from the interface unit reach the array.
  assign flash_wr_en = fiu_wr_req && fiu_wr_word;
  assign flash_wr_refused = (fiu_wr_req && !fiu_wr_word) || other_wr_req;

  always_comb begin
    mode_word = 32'h0;
    mode_word[boot_map_pkg::MODE_MA_BIT] = ma_q;
    mode_word[boot_map_pkg::MODE_MB_BIT] = mb_q;
    status_word = 32'h0;
    status_word[boot_map_pkg::ST_BOOT_EXT_BIT] = cfg_q.boot_external;
    status_word[boot_map_pkg::ST_ADDR20_BIT] = cfg_q.ext_addr_20;
    status_word[boot_map_pkg::ST_SECURED_BIT] = cfg_q.flash_secured;
    status_word[boot_map_pkg::ST_PSPACE_BIT] = cfg_q.ext_pspace_allowed;
    status_word[boot_map_pkg::ST_DBG_DIS_BIT] = cfg_q.debug_disabled;
    status_word[boot_map_pkg::ST_STRAP_REF_BIT] = strap_ref_q;
    status_word[boot_map_pkg::ST_WR_REF_BIT] = wr_ref_q;
    status_word[boot_map_pkg::ST_RD_CONF_BIT] = rd_conf_q;
    status_word[boot_map_pkg::ST_READY_BIT] = (state_q == boot_map_pkg::RUNNING);
  end

  // Next state of the bus side and the mode register.
  always_comb begin
    wr_pend_d = wr_take;
    wr_addr_d = wr_take ? haddr[7:0] : wr_addr_q;
    hrdata_d = hrdata_q;
    if (rd_en) begin
      unique case (haddr[7:0])
        boot_map_pkg::MODE_OFS: hrdata_d = mode_word;
        boot_map_pkg::STATUS_OFS: hrdata_d = status_word;
        default: hrdata_d = 32'h0;
      endcase
    end
    state_d = state_q;
    cnt_d = cnt_q;
    ma_d = ma_q;
    mb_d = mb_q;
    emi_d = emi_q;
    strap_ref_d = strap_ref_q;
    if (state_q == boot_map_pkg::SYNCING) begin
      cnt_d = cnt_q + 2'h1;
      if (capture) begin
        state_d = boot_map_pkg::RUNNING;
        mb_d = !flash_secured;
        ma_d = boot_strap_s && !flash_secured;
        emi_d = emi_strap_s;
        strap_ref_d = boot_strap_s && flash_secured;
      end
    end else if (wr_mode && mb_q) begin
      // A secured boot keeps the internal map; the security bit ignores writes.
      ma_d = hwdata[boot_map_pkg::MODE_MA_BIT];
    end
    // Hardware set wins over the write-one clear.
    wr_ref_d = (wr_ref_q && !(wr_status && hwdata[boot_map_pkg::ST_WR_REF_BIT])) || flash_wr_refused;
    rd_conf_d = (rd_conf_q && !(wr_status && hwdata[boot_map_pkg::ST_RD_CONF_BIT])) || rd_conflict;
  end

  // Map decode from the two mode bits.
  always_comb begin
    cfg_d = boot_map_pkg::CFG_RST;
    if (state_q == boot_map_pkg::RUNNING) begin
      cfg_d.boot_external = ma_q && mb_q;
      cfg_d.ext_addr_20 = ma_q && mb_q && emi_q;
      cfg_d.flash_secured = !mb_q;
      cfg_d.ext_pspace_allowed = mb_q;
      cfg_d.debug_disabled = !mb_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0;
      state_q <= boot_map_pkg::SYNCING;
      cnt_q <= 2'h0;
      ma_q <= 1'b0;
      mb_q <= 1'b0;
      emi_q <= 1'b0;
      strap_ref_q <= 1'b0;
      wr_ref_q <= 1'b0;
      rd_conf_q <= 1'b0;
      cfg_q <= boot_map_pkg::CFG_RST;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      ma_q <= ma_d;
      mb_q <= mb_d;
      emi_q <= emi_d;
      strap_ref_q <= strap_ref_d;
      wr_ref_q <= wr_ref_d;
      rd_conf_q <= rd_conf_d;
      cfg_q <= cfg_d;
    end
  end

  // Zero-wait slave: every transfer completes in one data phase.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign map_cfg = cfg_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic running;
  assign running = (state_q == boot_map_pkg::RUNNING);

  sequence s_both_one;
    running && ma_q && mb_q;
  endsequence
  sequence s_ext_cfg;
    map_cfg.boot_external && !map_cfg.flash_secured && (map_cfg.ext_addr_20 == emi_q);
  endsequence

  property p_map_follows;
    running |=> (map_cfg.boot_external == $past(ma_q && mb_q));
  endproperty
  a_map_follows: assert property (p_map_follows) else $error("map does not follow mode bits");

  property p_load;
    capture |=> running && (mb_q == !$past(flash_secured)) && (ma_q == ($past(boot_strap_s) && mb_q));
  endproperty
  a_load: assert property (p_load) else $error("mode bits not loaded at capture");

  property p_secured_cfg;
    (running && !ma_q && !mb_q) |=> map_cfg.flash_secured && map_cfg.debug_disabled
      && !map_cfg.ext_pspace_allowed && !map_cfg.boot_external && !map_cfg.ext_addr_20;
  endproperty
  a_secured_cfg: assert property (p_secured_cfg) else $error("mode 00 not secured internal");

  property p_refuse;
    running && !mb_q |-> !ma_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("external boot taken while secured");

  property p_pinned;
    (PIN_STRAPS && running) |-> !ma_q && !emi_q && !map_cfg.boot_external;
  endproperty
  a_pinned: assert property (p_pinned) else $error("pinned strap reached the map");

  property p_one_reader;
    (pread_req && sread_req) |-> pread_gnt && !sread_gnt;
  endproperty
  a_one_reader: assert property (p_one_reader) else $error("both flash readers granted");

  property p_wr_path;
    flash_wr_en |-> fiu_wr_req && fiu_wr_word && !flash_wr_refused;
  endproperty
  a_wr_path: assert property (p_wr_path) else $error("flash write from a wrong path");

  property p_ma_write;
    (running && wr_mode && mb_q) |=> (ma_q == $past(hwdata[0])) ##1 (map_cfg.boot_external == ma_q);
  endproperty
  a_ma_write: assert property (p_ma_write) else $error("map bit write lost");

  property p_mb_hold;
    running && $past(running) |-> $stable(mb_q);
  endproperty
  a_mb_hold: assert property (p_mb_hold) else $error("security bit changed after reset");

  property p_mode1;
    s_both_one |=> s_ext_cfg;
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 11 not external unsecured");

  // Register reads, sticky flags and captured values.
  property p_mode_read;
    (rd_en && haddr[7:0] == boot_map_pkg::MODE_OFS) |=> (hrdata[boot_map_pkg::MODE_MA_BIT] == $past(ma_q))
      && (hrdata[boot_map_pkg::MODE_MB_BIT] == $past(mb_q));
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode register read wrong");

  property p_wr_ref_set;
    flash_wr_refused |=> wr_ref_q;
  endproperty
  a_wr_ref_set: assert property (p_wr_ref_set) else $error("refused write not flagged");

  property p_wr_ref_clear;
    (wr_status && hwdata[boot_map_pkg::ST_WR_REF_BIT] && !flash_wr_refused) |=> !wr_ref_q;
  endproperty
  a_wr_ref_clear: assert property (p_wr_ref_clear) else $error("write refused flag not cleared");

  property p_rd_conf_set;
    (pread_req && sread_req) |=> rd_conf_q;
  endproperty
  a_rd_conf_set: assert property (p_rd_conf_set) else $error("read conflict not flagged");

  property p_strap_ref;
    capture |=> (strap_ref_q == ($past(boot_strap_s) && $past(flash_secured)));
  endproperty
  a_strap_ref: assert property (p_strap_ref) else $error("refused strap not recorded");

  property p_refused_mode;
    strap_ref_q |-> !ma_q && !mb_q;
  endproperty
  a_refused_mode: assert property (p_refused_mode) else $error("refused boot left a mode bit set");

  property p_stay_running;
    running |=> running && $stable(emi_q);
  endproperty
  a_stay_running: assert property (p_stay_running) else $error("captured strap changed after reset");
endmodule : boot_mode_program_map_select
`default_nettype wire

// ---- dv/flash_fetch_model.sv ----
// Behavioural model of the core fetch path and flash security logic facing the map block.
`default_nettype none
module flash_fetch_model (
  input wire logic secure_set, // Security state the test wants reported.
  input wire logic [1:0] rd_cmd, // Bit0 program-read, bit1 secondary-bus read.
  input wire logic [1:0] wr_cmd, // 0 idle, 1 word write, 2 partial write, 3 stray path.
  output logic flash_secured, // Reported security state.
  output logic pread_req, // Data flash read on the program-read bus.
  output logic sread_req, // Data flash read on the secondary bus.
  output logic fiu_wr_req, // Write through the interface unit.
  output logic fiu_wr_word, // That write is a whole word.
  output logic other_wr_req // Write attempt from elsewhere.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Security is a plain level; the block must only look at it during capture.
  assign flash_secured = secure_set;
  // Both reads may be raised together, so the block has to arbitrate between them.
  assign pread_req = rd_cmd[0];
  assign sread_req = rd_cmd[1];
  // Programming goes through the unit as whole words unless a test orders a faulty access.
  assign fiu_wr_req = (wr_cmd == 2'h1) || (wr_cmd == 2'h2);
  assign fiu_wr_word = (wr_cmd == 2'h1);
  assign other_wr_req = (wr_cmd == 2'h3);
endmodule : flash_fetch_model
`default_nettype wire

// ---- dv/boot_mode_program_map_select_test.sv ----
// Self-checking bench for the boot mode and program map selection block.
`default_nettype none
module boot_mode_program_map_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, rd_cmd = 2'h0, wr_cmd = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, boot_strap = 1'b0, mem_strap = 1'b0, secure_set = 1'b1;
  logic flash_secured, pread_req, sread_req, pread_gnt, sread_gnt;
  logic fiu_wr_req, fiu_wr_word, other_wr_req, flash_wr_en, flash_wr_refused;
  boot_map_pkg::map_cfg_t map_cfg;
  int miscompares = 0, comparisons = 0;
  // Strap pins are released so the refused and external boot paths can be reached.
  boot_mode_program_map_select #(.PIN_STRAPS(1'b0)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .external_boot_strap(boot_strap),
    .external_memory_mode_strap(mem_strap), .flash_secured(flash_secured), .map_cfg(map_cfg),
    .pread_req(pread_req), .sread_req(sread_req), .pread_gnt(pread_gnt), .sread_gnt(sread_gnt),
    .fiu_wr_req(fiu_wr_req), .fiu_wr_word(fiu_wr_word), .other_wr_req(other_wr_req),
    .flash_wr_en(flash_wr_en), .flash_wr_refused(flash_wr_refused));
  flash_fetch_model partner (.secure_set(secure_set), .rd_cmd(rd_cmd), .wr_cmd(wr_cmd),
    .flash_secured(flash_secured), .pread_req(pread_req), .sread_req(sread_req), .fiu_wr_req(fiu_wr_req),
    .fiu_wr_word(fiu_wr_word), .other_wr_req(other_wr_req));
  boot_map_pkg::map_cfg_t pinned_cfg;
  // A second copy keeps the default pinned straps, so the tied-low path is exercised with the pins high.
  boot_mode_program_map_select pinned (.hclk(hclk), .hresetn(hresetn), .hsel(1'b0), .haddr(32'h0),
    .htrans(2'h0), .hwrite(1'b0), .hsize(3'h2), .hwdata(32'h0), .hready(1'b1), .hreadyout(), .hresp(),
    .hrdata(), .external_boot_strap(boot_strap), .external_memory_mode_strap(mem_strap),
    .flash_secured(flash_secured), .map_cfg(pinned_cfg), .pread_req(1'b0), .sread_req(1'b0), .pread_gnt(),
    .sread_gnt(), .fiu_wr_req(1'b0), .fiu_wr_word(1'b0), .other_wr_req(1'b0), .flash_wr_en(),
    .flash_wr_refused());
  initial begin
    forever #5 hclk = ~hclk;
  end
  // Prints the counts and the verdict, then stops the run.
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      miscompares++;
    end
  endtask : check
  // Waits for hready with a bound, so a stuck slave ends the run instead of hanging it.
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      $display("wrong value at %0t: bus never ready", $time);
      miscompares++;
      results();
    end
  endtask : wait_ready
  // One single AHB-Lite word transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask : bus
  task automatic reg_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0, rd);
    check({31'h0, hresp}, 32'h0, "response");
    check(rd & mask, exp, m);
  endtask : reg_check
  // Reset with the given security state and straps, then let capture finish.
  task automatic boot(input logic sec, input logic strap, input logic emm);
    hresetn <= 1'b0;
    secure_set <= sec;
    boot_strap <= strap;
    mem_strap <= emm;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : boot
  initial begin
    // Secured flash with the boot strap asking for external boot must fall back to mode 0.
    boot(1'b1, 1'b1, 1'b1);
    reg_check(8'h00, 32'h3, 32'h0, "mode refused");
    reg_check(8'h04, 32'h13F, 32'h134, "status refused");
    check({27'h0, map_cfg}, 32'h05, "mode 0 map");
    bus(1'b1, 8'h00, 32'h1, rd);
    reg_check(8'h00, 32'h3, 32'h0, "map bit locked");
    // Unsecured flash with external boot strap gives mode 1 with the wide bus.
    boot(1'b0, 1'b1, 1'b1);
    reg_check(8'h00, 32'h3, 32'h3, "mode 1");
    check({27'h0, map_cfg & 5'h1C}, 32'h18, "mode 1 map");
    check({27'h0, pinned_cfg}, 32'h02, "pinned straps");
    secure_set <= 1'b1;
    reg_check(8'h00, 32'h3, 32'h3, "security bit held");
    check({27'h0, map_cfg & 5'h04}, 32'h0, "security kept");
    bus(1'b1, 8'h00, 32'h0, rd);
    reg_check(8'h00, 32'h3, 32'h2, "map bit cleared");
    @(posedge hclk);
    check({27'h0, map_cfg & 5'h10}, 32'h0, "internal map");
    bus(1'b1, 8'h00, 32'h1, rd);
    repeat (2) @(posedge hclk);
    check({27'h0, map_cfg & 5'h10}, 32'h10, "external map");
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF, rd);
    reg_check(8'h0C, 32'hFFFF_FFFF, 32'h0, "unmapped");
    reg_check(8'h00, 32'h3, 32'h3, "mode kept");
    // Unsecured flash with the strap low stays internal with narrow bus.
    boot(1'b0, 1'b0, 1'b0);
    reg_check(8'h00, 32'h3, 32'h2, "unsecured internal");
    check({27'h0, map_cfg & 5'h1C}, 32'h0, "internal unsecured map");
    // Every read request combination; the program-read bus wins a conflict.
    for (int m = 0; m < 4; m++) begin
      rd_cmd <= m[1:0];
      @(posedge hclk);
      #1;
      check({30'h0, pread_gnt, sread_gnt}, {30'h0, m[0], m[1] & ~m[0]}, "read grants");
    end
    rd_cmd <= 2'h0;
    reg_check(8'h04, 32'h80, 32'h80, "conflict flag");
    bus(1'b1, 8'h04, 32'h80, rd);
    reg_check(8'h04, 32'h80, 32'h0, "conflict cleared");
    // Each write path; only whole words through the unit may program.
    for (int m = 0; m < 4; m++) begin
      wr_cmd <= m[1:0];
      @(posedge hclk);
      #1;
      check({30'h0, flash_wr_en, flash_wr_refused}, {30'h0, m == 1, m > 1}, "write path");
    end
    wr_cmd <= 2'h0;
    reg_check(8'h04, 32'h40, 32'h40, "write refused flag");
    bus(1'b1, 8'h04, 32'h40, rd);
    reg_check(8'h04, 32'h40, 32'h0, "write flag cleared");
    results();
  end
endmodule : boot_mode_program_map_select_test
`default_nettype wire
